// file: bench/dtap_gen_test.sv
// Testbench for the alarm and pattern override block.
// Assumes APB with pready from the block, one stream bit per transfer.
`timescale 1ns/10ps
module dtap_gen_test;
   logic                pclk, presetn, psel, penable, pwrite;
   logic                pready, pslverr, err, line_q, sof_nx;
   logic [7:0]          paddr, pat;
   logic [31:0]         pwdata, prdata, rd;
   logic [3:0]          pstrb;
   logic                rx_los, rx_oof, rx_ais, in_valid, out_valid;
   dtap_pkg::dtap_bit_t in_bit, out_bit;
   logic [15:0]         count_q;
   int                  fails, check_count, sent;

   dtap_gen u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_los(rx_los), .rx_oof(rx_oof), .rx_ais(rx_ais),
      .in_valid(in_valid), .in_bit(in_bit), .out_valid(out_valid),
      .out_bit(out_bit));
   dtap_liu_model u_liu (.pclk(pclk), .presetn(presetn),
      .out_valid(out_valid), .out_bit(out_bit), .line_q(line_q),
      .count_q(count_q));

   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'h1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic xfer(input dtap_pkg::dtap_kind_t k, input logic [2:0] sf,
                       input logic v);
      @(posedge pclk);
      in_valid <= 1'h1;
      in_bit   <= '{sof: sof_nx, subframe: sf, kind: k, value: v};
      @(posedge pclk);
      in_valid <= 1'h0;
      @(posedge pclk);
      // Line level is settled one edge after the model takes it
      @(posedge pclk);
      sent++;
   endtask

   task automatic send(input dtap_pkg::dtap_kind_t k, input logic [2:0] sf,
                       input logic v, input logic e);
      xfer(k, sf, v);
      chk({31'h0, line_q}, {31'h0, e});
   endtask

   // Pattern phase carries over from earlier pattern payload bits, so any rotation is accepted
   function automatic logic rot_ok(input logic [7:0] g, input logic [3:0] p);
      logic [7:0] r;
      rot_ok = 1'h0;
      r = {p, p};
      for (int j = 0; j < 4; j++) begin
         if (g === r) rot_ok = 1'h1;
         r = {r[6:0], r[7]};
      end
   endfunction

   task automatic pat_chk(input logic v, input logic [3:0] p);
      for (int j = 0; j < 8; j++) begin
         xfer(dtap_pkg::KIND_PAYLOAD, 3'h1, v);
         pat = {pat[6:0], line_q};
      end
      chk({31'h0, rot_ok(pat, p)}, 32'h1);
   endtask

   task automatic stop_test;
      if (fails == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Clock and watchdog
   initial begin
      pclk = 1'h0;
      forever #2 pclk = ~pclk;
   end

   // A full run takes far less than this span of 25000 cycles
   initial begin
      #100000;
      fails++;
      stop_test();
   end

   // ==========================================================
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, rx_los, rx_oof, rx_ais} = 7'h00;
      {paddr, pwdata, pstrb, in_valid, pat, sof_nx} = '0;
      in_bit = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, dtap_pkg::ADDR_CFG, 32'h0, 4'h0);
      chk(rd, 32'h2B);
      send(dtap_pkg::KIND_M, 3'h1, 1'h1, 1'h0);
      apb(1'h1, dtap_pkg::ADDR_CFG, 32'hFF, 4'h0);
      apb(1'h0, dtap_pkg::ADDR_CFG, 32'h0, 4'h0);
      chk(rd, 32'h2B);
      apb(1'h0, 8'h34, 32'h0, 4'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'h1, dtap_pkg::ADDR_CFG, 32'h00, 4'hF);
      chk({31'h0, err}, 32'h0);
      send(dtap_pkg::KIND_X, 3'h1, 1'h1, 1'h1);
      send(dtap_pkg::KIND_X, 3'h1, 1'h0, 1'h0);
      send(dtap_pkg::KIND_C, 3'h3, 1'h1, 1'h1);
      send(dtap_pkg::KIND_PAYLOAD, 3'h2, 1'h1, 1'h1);
      // A frame holding a single payload one gives odd parity next frame
      sof_nx = 1'h1;
      send(dtap_pkg::KIND_M, 3'h1, 1'h1, 1'h1);
      sof_nx = 1'h0;
      send(dtap_pkg::KIND_PAYLOAD, 3'h1, 1'h1, 1'h1);
      sof_nx = 1'h1;
      send(dtap_pkg::KIND_M, 3'h1, 1'h1, 1'h1);
      sof_nx = 1'h0;
      apb(1'h1, dtap_pkg::ADDR_CFG, 32'h80, 4'hF);
      send(dtap_pkg::KIND_X, 3'h1, 1'h1, 1'h0);
      send(dtap_pkg::KIND_PAYLOAD, 3'h1, 1'h1, 1'h1);
      apb(1'h1, dtap_pkg::ADDR_CFG, 32'h40, 4'hF);
      send(dtap_pkg::KIND_X, 3'h1, 1'h0, 1'h1);
      send(dtap_pkg::KIND_PAYLOAD, 3'h1, 1'h0, 1'h0);
      apb(1'h1, dtap_pkg::ADDR_CFG, 32'hC0, 4'hF);
      send(dtap_pkg::KIND_X, 3'h1, 1'h1, 1'h0);
      apb(1'h1, dtap_pkg::ADDR_CFG, 32'hE0, 4'hF);
      send(dtap_pkg::KIND_X, 3'h1, 1'h0, 1'h1);
      send(dtap_pkg::KIND_C, 3'h3, 1'h1, 1'h0);
      send(dtap_pkg::KIND_C, 3'h1, 1'h1, 1'h1);
      send(dtap_pkg::KIND_M, 3'h1, 1'h1, 1'h1);
      send(dtap_pkg::KIND_P, 3'h1, 1'h0, 1'h1);
      pat_chk(1'h1, dtap_pkg::PAT_IDLE);
      apb(1'h1, dtap_pkg::ADDR_CFG, 32'h30, 4'hF);
      send(dtap_pkg::KIND_X, 3'h1, 1'h0, 1'h1);
      send(dtap_pkg::KIND_C, 3'h1, 1'h1, 1'h0);
      send(dtap_pkg::KIND_F, 3'h1, 1'h1, 1'h1);
      send(dtap_pkg::KIND_P, 3'h1, 1'h0, 1'h1);
      pat_chk(1'h0, dtap_pkg::PAT_AIS);
      apb(1'h1, dtap_pkg::ADDR_CFG, 32'hF8, 4'hF);
      send(dtap_pkg::KIND_M, 3'h1, 1'h1, 1'h0);
      send(dtap_pkg::KIND_F, 3'h1, 1'h1, 1'h0);
      send(dtap_pkg::KIND_PAYLOAD, 3'h1, 1'h1, 1'h0);
      // Each receive condition tried with its own enable, then the others
      for (int i = 0; i < 3; i++) begin
         {rx_los, rx_oof, rx_ais} <= 3'h4 >> i;
         apb(1'h1, dtap_pkg::ADDR_CFG, 32'h4 >> i, 4'hF);
         send(dtap_pkg::KIND_X, 3'h1, 1'h1, 1'h0);
         apb(1'h1, dtap_pkg::ADDR_CFG, ~(32'h4 >> i) & 32'h7, 4'hF);
         send(dtap_pkg::KIND_X, 3'h1, 1'h1, 1'h1);
      end
      {rx_los, rx_oof, rx_ais} <= 3'h4;
      apb(1'h1, dtap_pkg::ADDR_CFG, 32'h24, 4'hF);
      send(dtap_pkg::KIND_X, 3'h1, 1'h0, 1'h1);
      // Status: idle mode code 3, auto alarm raised, receive LOS seen
      apb(1'h0, dtap_pkg::ADDR_STATUS, 32'h0, 4'h0);
      chk(rd, 32'h1B);
      apb(1'h1, dtap_pkg::ADDR_STATUS, 32'h0, 4'hF);
      chk({31'h0, err}, 32'h1);
      chk({16'h0, count_q}, sent);
      stop_test();
   end
endmodule

// file: bench/dtap_liu_model.sv
// Line interface model: takes the outbound bits of the alarm block.
// Assumes one bit per pclk cycle while out_valid is high.
`timescale 1ns/10ps
module dtap_liu_model (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                out_valid,
   input  wire dtap_pkg::dtap_bit_t out_bit,
   output logic                     line_q,
   output logic [15:0]              count_q
);
   // ==========================================================
   // Line capture
   // The line never stalls, so every valid bit is taken at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_q  <= 1'h1;
         count_q <= 16'h0000;
      end else if (out_valid) begin
         line_q  <= out_bit.value;
         count_q <= count_q + 16'h0001;
      end
   end
endmodule

// file: rtl/dtap_gen.sv
// DS3 transmit alarm and maintenance pattern override, with APB access.
// Assumes the frame mux upstream tags each bit and the receive section
// reports its loss, out-of-frame and AIS conditions as levels on pclk.
//
// How it works
// - Forced yellow drives X-bits to zero
// - Normal X-bits follow near-end receive conditions
// - Forced yellow ignored under idle, AIS, LOS
// - Force X ones drives X-bits high
// - X ones yields to yellow, AIS, idle, LOS
// - Idle: X ones, CP zero, payload 1100
// - Idle ignored under AIS or LOS
// - AIS: X ones, C zero, payload 1010
// - AIS ignored under LOS
// - LOS pattern sends all zeros everywhere
// - LOS pattern outranks every other setting
// - Otherwise overhead and payload pass through
// - Auto yellow on receive signal loss
// - Auto yellow on receive out-of-frame
// - Auto yellow on receive AIS
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module dtap_gen (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   input  wire logic [3:0]       pstrb,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             rx_los,
   input  wire logic             rx_oof,
   input  wire logic             rx_ais,
   input  wire logic             in_valid,
   input  wire dtap_pkg::dtap_bit_t in_bit,
   output logic                  out_valid,
   output dtap_pkg::dtap_bit_t   out_bit
);

   // ==========================================================
   // APB slave decode
   logic [dtap_pkg::CFG_W-1:0]    cfg_q;
   logic [dtap_pkg::STATUS_W-1:0] status;
   logic [31:0]                   prdata_q;
   logic                          hit_cfg;
   logic                          hit_status;
   logic                          setup_ph;
   logic                          access_ph;
   logic                          cfg_we;
   logic [31:0]                   rd_mux;

   // Zero wait states; read data is latched in the setup cycle
   assign hit_cfg    = paddr == dtap_pkg::ADDR_CFG;
   assign hit_status = paddr == dtap_pkg::ADDR_STATUS;
   assign setup_ph   = psel & ~penable;
   assign access_ph  = psel & penable;
   assign pready     = 1'h1;
   assign pslverr    = access_ph & ~(hit_cfg | (hit_status & ~pwrite));
   assign cfg_we     = access_ph & pwrite & hit_cfg & pstrb[0];
   assign prdata     = prdata_q;
   assign rd_mux     = hit_cfg    ? {24'h000000, cfg_q} :
                       hit_status ? {25'h0000000, status} : 32'h00000000;

   // Configuration register; status is read-only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q    <= dtap_pkg::CFG_RESET;
         prdata_q <= 32'h00000000;
      end else begin
         if (cfg_we) begin
            cfg_q <= pwdata[dtap_pkg::CFG_W-1:0];
         end
         if (setup_ph && !pwrite) begin
            prdata_q <= rd_mux;
         end
      end
   end

   // ==========================================================
   // Mode selection
   logic                 auto_los;
   logic                 auto_oof;
   logic                 auto_ais;
   logic                 auto_alarm;
   logic                 yellow_req;
   dtap_pkg::dtap_mode_t mode;

   assign auto_los = cfg_q[dtap_pkg::BIT_AUTO_ON_LOS] & rx_los;
   assign auto_oof = cfg_q[dtap_pkg::BIT_AUTO_ON_OOF] & rx_oof;
   assign auto_ais = cfg_q[dtap_pkg::BIT_AUTO_ON_AIS] & rx_ais;
   assign auto_alarm = auto_los | auto_oof | auto_ais;
   assign yellow_req = cfg_q[dtap_pkg::BIT_FORCE_YELLOW] | auto_alarm;

   // Fixed priority; the tail of the chain is what every pattern beats
   // LOS first
   assign mode =
      cfg_q[dtap_pkg::BIT_LOS_PATTERN]  ? dtap_pkg::MODE_LOS    :
      cfg_q[dtap_pkg::BIT_AIS_PATTERN]  ? dtap_pkg::MODE_AIS    :
      cfg_q[dtap_pkg::BIT_IDLE_PATTERN] ? dtap_pkg::MODE_IDLE   :
      yellow_req                        ? dtap_pkg::MODE_YELLOW :
      cfg_q[dtap_pkg::BIT_FORCE_X_ONES] ? dtap_pkg::MODE_X_ONES :
                                          dtap_pkg::MODE_NORMAL;

   assign status = {rx_ais, rx_oof, rx_los, auto_alarm, mode};

   // ==========================================================
   // Pattern phase and regenerated parity
   logic [1:0] phase_q;
   logic       par_acc_q;
   logic       par_q;
   logic       pattern_on;
   logic       is_payload;
   logic       pat_bit;
   logic       out_value;
   logic       par_next;

   assign pattern_on = (mode == dtap_pkg::MODE_IDLE) ||
                       (mode == dtap_pkg::MODE_AIS);
   assign is_payload = in_bit.kind == dtap_pkg::KIND_PAYLOAD;
   assign pat_bit    = (mode == dtap_pkg::MODE_IDLE) ?
                       dtap_pkg::PAT_IDLE[2'h3 - phase_q] :
                       dtap_pkg::PAT_AIS[2'h3 - phase_q];
   // Parity over payload actually sent, so P stays valid after overwrite
   assign par_next   = (in_bit.sof ? 1'h0 : par_acc_q) ^
                       (is_payload & out_value);

   // Phase steps on each payload bit in idle or AIS mode; parity of a frame is used next frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q   <= 2'h0;
         par_acc_q <= 1'h0;
         par_q     <= 1'h0;
      end else if (in_valid) begin
         if (is_payload && pattern_on) begin
            phase_q <= phase_q + 2'h1;
         end
         if (in_bit.sof) begin
            par_q <= par_acc_q;
         end
         par_acc_q <= par_next;
      end
   end

   // ==========================================================
   // Bit override
   always_comb begin
      out_value = in_bit.value;
      case (mode)
         dtap_pkg::MODE_LOS: begin
            out_value = dtap_pkg::LOS_LEVEL;
         end
         dtap_pkg::MODE_AIS: begin
            case (in_bit.kind)
               dtap_pkg::KIND_PAYLOAD: out_value = pat_bit;
               dtap_pkg::KIND_X:       out_value = dtap_pkg::X_ONES;
               dtap_pkg::KIND_C:       out_value = dtap_pkg::C_CLEAR;
               dtap_pkg::KIND_P:       out_value = par_q;
               default:                out_value = in_bit.value;
            endcase
         end
         dtap_pkg::MODE_IDLE: begin
            case (in_bit.kind)
               dtap_pkg::KIND_PAYLOAD: out_value = pat_bit;
               dtap_pkg::KIND_X:       out_value = dtap_pkg::X_ONES;
               dtap_pkg::KIND_C: begin
                  if (in_bit.subframe == dtap_pkg::CP_SUBFRAME) begin
                     out_value = dtap_pkg::C_CLEAR;
                  end
               end
               dtap_pkg::KIND_P:       out_value = par_q;
               default:                out_value = in_bit.value;
            endcase
         end
         dtap_pkg::MODE_YELLOW: begin
            if (in_bit.kind == dtap_pkg::KIND_X) begin
               out_value = dtap_pkg::X_ALARM;
            end
         end
         dtap_pkg::MODE_X_ONES: begin
            if (in_bit.kind == dtap_pkg::KIND_X) begin
               out_value = dtap_pkg::X_ONES;
            end
         end
         default: begin
            out_value = in_bit.value;
         end
      endcase
   end

   // ==========================================================
   // Output stage, one cycle after the input bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'h0;
         out_bit   <= '0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_bit <= '{sof: in_bit.sof, subframe: in_bit.subframe,
                         kind: in_bit.kind, value: out_value};
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   los_all_zero_a: assert property (
      out_valid && $past(cfg_q[dtap_pkg::BIT_LOS_PATTERN])
      |-> out_bit.value == 1'h0)
      else $error("LOS pattern sent a one");

   ais_x_high_a: assert property (
      out_valid && out_bit.kind == dtap_pkg::KIND_X &&
      $past(cfg_q[dtap_pkg::BIT_AIS_PATTERN]) &&
      !$past(cfg_q[dtap_pkg::BIT_LOS_PATTERN])
      |-> out_bit.value)
      else $error("AIS X-bit not high");

   ais_c_low_a: assert property (
      out_valid && out_bit.kind == dtap_pkg::KIND_C &&
      $past(cfg_q[dtap_pkg::BIT_AIS_PATTERN]) &&
      !$past(cfg_q[dtap_pkg::BIT_LOS_PATTERN])
      |-> !out_bit.value)
      else $error("AIS C-bit not low");

   idle_cp_low_a: assert property (
      out_valid && out_bit.kind == dtap_pkg::KIND_C &&
      out_bit.subframe == dtap_pkg::CP_SUBFRAME &&
      $past(mode == dtap_pkg::MODE_IDLE)
      |-> !out_bit.value)
      else $error("Idle CP-bit not low");

   yellow_x_low_a: assert property (
      out_valid && out_bit.kind == dtap_pkg::KIND_X &&
      $past(cfg_q[dtap_pkg::BIT_FORCE_YELLOW]) &&
      $past(cfg_q[5:3]) == 3'h0
      |-> !out_bit.value)
      else $error("Forced yellow X-bit not low");

   auto_los_a: assert property (
      out_valid && out_bit.kind == dtap_pkg::KIND_X &&
      $past(rx_los && cfg_q[dtap_pkg::BIT_AUTO_ON_LOS]) &&
      $past(cfg_q[5:3]) == 3'h0
      |-> !out_bit.value)
      else $error("Auto yellow on LOS missing");

   // Judged from the register and alarm request, not from the mode code
   x_ones_a: assert property (
      out_valid && out_bit.kind == dtap_pkg::KIND_X &&
      $past(cfg_q[dtap_pkg::BIT_FORCE_X_ONES] && !yellow_req) &&
      $past(cfg_q[5:3]) == 3'h0
      |-> out_bit.value)
      else $error("X ones wrong");

   payload_pass_a: assert property (
      in_valid && (mode == dtap_pkg::MODE_NORMAL ||
                   mode == dtap_pkg::MODE_YELLOW)
      |=> out_valid && out_bit.value == $past(in_bit.value) ||
          out_bit.kind == dtap_pkg::KIND_X)
      else $error("Payload altered in normal mode");

   idle_seq_a: assert property (
      in_valid && is_payload && mode == dtap_pkg::MODE_IDLE &&
      phase_q == 2'h0
      |=> out_bit.value)
      else $error("Idle pattern phase wrong");

   cfg_write_a: assert property (
      cfg_we |=> cfg_q == $past(pwdata[dtap_pkg::CFG_W-1:0]))
      else $error("Config write lost");

   auto_oof_a: assert property (
      out_valid && out_bit.kind == dtap_pkg::KIND_X &&
      $past(rx_oof && cfg_q[dtap_pkg::BIT_AUTO_ON_OOF]) &&
      $past(cfg_q[5:3]) == 3'h0
      |-> !out_bit.value)
      else $error("Auto yellow on OOF missing");

   auto_ais_a: assert property (
      out_valid && out_bit.kind == dtap_pkg::KIND_X &&
      $past(rx_ais && cfg_q[dtap_pkg::BIT_AUTO_ON_AIS]) &&
      $past(cfg_q[5:3]) == 3'h0
      |-> !out_bit.value)
      else $error("Auto yellow on AIS missing");

   x_follow_a: assert property (
      in_valid && in_bit.kind == dtap_pkg::KIND_X &&
      cfg_q[dtap_pkg::BIT_FORCE_YELLOW:dtap_pkg::BIT_LOS_PATTERN] == 5'h00 &&
      !(cfg_q[dtap_pkg::BIT_AUTO_ON_LOS] && rx_los) &&
      !(cfg_q[dtap_pkg::BIT_AUTO_ON_OOF] && rx_oof) &&
      !(cfg_q[dtap_pkg::BIT_AUTO_ON_AIS] && rx_ais)
      |=> out_bit.value == $past(in_bit.value))
      else $error("X-bit not passed through");

   pat_x_high_a: assert property (
      out_valid && out_bit.kind == dtap_pkg::KIND_X &&
      $past(cfg_q[dtap_pkg::BIT_IDLE_PATTERN]) &&
      !$past(cfg_q[dtap_pkg::BIT_LOS_PATTERN])
      |-> out_bit.value)
      else $error("Pattern X-bit not high");

   frame_keep_a: assert property (
      out_valid && $past(in_bit.kind == dtap_pkg::KIND_M ||
                         in_bit.kind == dtap_pkg::KIND_F) &&
      $past(cfg_q[dtap_pkg::BIT_AIS_PATTERN]) &&
      !$past(cfg_q[dtap_pkg::BIT_LOS_PATTERN])
      |-> out_bit.value == $past(in_bit.value))
      else $error("AIS altered an M or F bit");

   // A write with the low strobe off must not touch the register
   strobe_mask_a: assert property (
      access_ph && pwrite && !pstrb[0] |=> $stable(cfg_q))
      else $error("Masked write changed config");

   stream_lat_a: assert property (out_valid == $past(in_valid))
      else $error("Output valid not one cycle late");

   cov_ais_c: cover property (out_valid && mode == dtap_pkg::MODE_AIS);
   cov_idle_c: cover property (out_valid && mode == dtap_pkg::MODE_IDLE);
   cov_auto_c: cover property (auto_alarm && out_valid);
   cov_los_c: cover property (mode == dtap_pkg::MODE_LOS ##1 cfg_we);
   cov_yellow_c: cover property (out_valid && mode == dtap_pkg::MODE_YELLOW);

endmodule

// file: rtl/dtap_pkg.sv
// Package for the DS3 transmit alarm and pattern override block.
// Assumes a bit-serial outbound stream tagged with the kind of each bit.
package dtap_pkg;

   // ==========================================================
   // Register map (byte addresses, one 32-bit word each)
   localparam logic [7:0] ADDR_CFG    = 8'h30;
   localparam logic [7:0] ADDR_STATUS = 8'h3C;
   localparam logic [7:0] CFG_RESET   = 8'h2B;
   localparam int         CFG_W       = 8;
   localparam int         STATUS_W    = 7;

   // ==========================================================
   // Configuration field positions
   localparam int BIT_FORCE_YELLOW  = 7;
   localparam int BIT_FORCE_X_ONES  = 6;
   localparam int BIT_IDLE_PATTERN  = 5;
   localparam int BIT_AIS_PATTERN   = 4;
   localparam int BIT_LOS_PATTERN   = 3;
   localparam int BIT_AUTO_ON_LOS   = 2;
   localparam int BIT_AUTO_ON_OOF   = 1;
   localparam int BIT_AUTO_ON_AIS   = 0;

   // ==========================================================
   // Status field positions
   localparam int ST_MODE_LSB   = 0;
   localparam int ST_MODE_MSB   = 2;
   localparam int ST_AUTO_ALARM = 3;
   localparam int ST_RX_LOS     = 4;
   localparam int ST_RX_OOF     = 5;
   localparam int ST_RX_AIS     = 6;

   // ==========================================================
   // Patterns, sent most significant bit first
   localparam logic [3:0] PAT_IDLE    = 4'hC;
   localparam logic [3:0] PAT_AIS     = 4'hA;
   localparam logic [2:0] CP_SUBFRAME = 3'h3;
   localparam logic       X_ALARM     = 1'h0;
   localparam logic       X_ONES      = 1'h1;
   localparam logic       C_CLEAR     = 1'h0;
   localparam logic       LOS_LEVEL   = 1'h0;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      KIND_PAYLOAD, KIND_X, KIND_P, KIND_M, KIND_F, KIND_C
   } dtap_kind_t;

   typedef enum logic [2:0] {
      MODE_NORMAL, MODE_X_ONES, MODE_YELLOW, MODE_IDLE, MODE_AIS,
      MODE_LOS
   } dtap_mode_t;

   typedef struct packed {
      logic       sof;       // First bit of a DS3 frame
      logic [2:0] subframe;  // Subframe number 1..7
      dtap_kind_t kind;
      logic       value;
   } dtap_bit_t;

endpackage
